// >>> inc/ptp_timer_pkg.sv
// constants, field layout and carrier types of the precision clock and event timer
// assumes a classic wishbone master and one clock that stands for the reference clock
package ptp_timer_pkg;

    // register byte addresses, channel stride and half offset
    localparam logic [7:0] OFF_CMD       = 8'h00;
    localparam logic [7:0] OFF_CLK_SEC   = 8'h04;
    localparam logic [7:0] OFF_CLK_NS    = 8'h08;
    localparam logic [7:0] OFF_CLK_SUB   = 8'h0c;
    localparam logic [7:0] OFF_TRIM      = 8'h10;
    localparam logic [7:0] OFF_STEP      = 8'h14;
    localparam logic [7:0] OFF_TEMP_RATE = 8'h18;
    localparam logic [7:0] OFF_TEMP_LEN  = 8'h1c;
    localparam logic [7:0] OFF_CONFIG    = 8'h20;
    localparam logic [7:0] OFF_STATUS    = 8'h24;
    localparam logic [7:0] OFF_TGT_BASE  = 8'h28;
    localparam logic [7:0] OFF_RLD_BASE  = 8'h38;
    localparam logic [7:0] OFF_CH_STRIDE = 8'h08;
    localparam logic [7:0] OFF_NS_HALF   = 8'h04;

    // command bits, all self clearing
    localparam int CMD_SNAP     = 0;
    localparam int CMD_LOAD     = 1;
    localparam int CMD_STEP_SEC = 2;
    localparam int CMD_STEP_NS  = 3;
    localparam int CMD_TEMP     = 4;
    localparam int CMD_TGT_READ = 5;
    localparam int CMD_W        = 6;

    // amount in the low bits, direction in bit 31 (1 = faster or subtract), ignored by the nanosecond step
    localparam int DIR_BIT = 31;
    localparam int NCH     = 2;

    localparam logic [29:0] NS_WRAP   = 30'h3b9aca00;
    localparam logic [30:0] NS_WRAP31 = 31'h3b9aca00;
    localparam logic [29:0] INC_NORM  = 30'h00a;
    localparam logic [29:0] INC_FAST  = 30'h00b;
    localparam logic [29:0] INC_SLOW  = 30'h009;

    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    typedef struct packed {
        logic [31:0] sec;
        logic [29:0] ns;
    } time_t;

    typedef struct packed {
        logic       cyc;
        logic       stb;
        logic       we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

endpackage

// >>> core/ptp_clock_event_timer.sv
// precision clock with rate trim, steps, temporary rate and two compare channels
// assumes a classic wishbone master on clk_i; each rising clk_i edge is one reference period
`timescale 1ns/1ps
`default_nettype none

module ptp_clock_event_timer (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire ptp_timer_pkg::wb_req_t  wb_req_i,
    output logic [31:0]                  wb_dat_o,
    output logic                         wb_ack_o,
    output logic [ptp_timer_pkg::NCH-1:0] channel_event_o,
    output logic [ptp_timer_pkg::NCH-1:0] time_event_status_o
);
    import ptp_timer_pkg::*;
    logic [31:0]         sec,        next_sec;
    logic [29:0]         ns,         next_ns;
    logic [31:0]         sub,        next_sub;
    logic [CMD_W-1:0]    cmd,        next_cmd;
    logic [31:0]         val_sec,    next_val_sec;
    logic [29:0]         val_ns,     next_val_ns;
    logic [31:0]         val_sub,    next_val_sub;
    logic [31:0]         trim,       next_trim;
    logic [31:0]         step,       next_step;
    logic [31:0]         temp_rate,  next_temp_rate;
    logic [31:0]         temp_len,   next_temp_len;
    logic [31:0]         temp_left,  next_temp_left;
    logic                temp_on,    next_temp_on;
    logic [NCH-1:0]      reload_sel, next_reload_sel;
    logic [NCH-1:0]      status,     next_status;
    logic [NCH-1:0]      evt,        next_evt;
    logic                ack,        next_ack;
    logic [31:0]         rdata,      next_rdata;
    time_t               tgt_stage  [NCH];
    time_t               next_tgt_stage [NCH];
    time_t               tgt        [NCH];
    time_t               next_tgt   [NCH];
    time_t               rld_stage  [NCH];
    time_t               next_rld_stage [NCH];
    time_t               rld        [NCH];
    time_t               next_rld   [NCH];
    logic [1:0]          tgt_half   [NCH];
    logic [1:0]          next_tgt_half [NCH];
    logic [1:0]          rld_half   [NCH];
    logic [1:0]          next_rld_half [NCH];

    logic                wr;
    logic                rd;
    logic [30:0]         rate_amt;
    logic                rate_dir;
    logic [32:0]         sub_sum;
    logic                sub_wrap;
    logic [29:0]         addend;
    logic [30:0]         ns_sum;
    logic                ns_carry;
    logic [NCH-1:0]      hit;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // nanosecond part folds once; halves hold values below 10^9
    function automatic time_t add_time(input time_t a, input time_t b);
        time_t       r;
        logic [30:0] s;
        s = {1'b0, a.ns} + {1'b0, b.ns};
        if (s >= NS_WRAP31) begin
            r.ns  = 30'(s - NS_WRAP31);
            r.sec = a.sec + b.sec + 32'h0000_0001;
        end else begin
            r.ns  = s[29:0];
            r.sec = a.sec + b.sec;
        end
        return r;
    endfunction

    function automatic logic [7:0] ch_addr(input logic [7:0] base, input int ch,
                                           input logic ns_half);
        return 8'(int'(base) + ch * int'(OFF_CH_STRIDE) + (ns_half ? int'(OFF_NS_HALF) : 0));
    endfunction

    assign wr = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ack;
    assign rd = wb_req_i.cyc & wb_req_i.stb & ~ack;

    always_comb begin
        next_sec        = sec;
        next_ns         = ns;
        next_sub        = sub;
        next_cmd        = '0;
        next_val_sec    = val_sec;
        next_val_ns     = val_ns;
        next_val_sub    = val_sub;
        next_trim       = trim;
        next_step       = step;
        next_temp_rate  = temp_rate;
        next_temp_len   = temp_len;
        next_temp_left  = temp_left;
        next_temp_on    = temp_on;
        next_reload_sel = reload_sel;
        next_status     = status;
        next_evt        = '0;
        next_tgt_stage  = tgt_stage;
        next_tgt        = tgt;
        next_rld_stage  = rld_stage;
        next_rld        = rld;
        next_tgt_half   = tgt_half;
        next_rld_half   = rld_half;
        // one cycle answer; ack drops after one cycle so writes never follow back to back
        next_ack        = wb_req_i.cyc & wb_req_i.stb & ~ack;
        next_rdata      = rdata;

        if (rd) begin
            unique case (wb_req_i.adr)
                OFF_CMD:       next_rdata = {26'h0, cmd};
                OFF_CLK_SEC:   next_rdata = val_sec;
                OFF_CLK_NS:    next_rdata = {2'h0, val_ns};
                OFF_CLK_SUB:   next_rdata = val_sub;
                OFF_TRIM:      next_rdata = trim;
                OFF_STEP:      next_rdata = step;
                OFF_TEMP_RATE: next_rdata = temp_rate;
                OFF_TEMP_LEN:  next_rdata = temp_len;
                OFF_CONFIG:    next_rdata = {30'h0, reload_sel};
                OFF_STATUS:    next_rdata = {30'h0, status};
                default:       next_rdata = RESET_WORD;
            endcase
            for (int ch = 0; ch < NCH; ch++) begin
                if (wb_req_i.adr == ch_addr(OFF_TGT_BASE, ch, 1'b0)) begin
                    next_rdata = tgt_stage[ch].sec;
                end
                if (wb_req_i.adr == ch_addr(OFF_TGT_BASE, ch, 1'b1)) begin
                    next_rdata = {2'h0, tgt_stage[ch].ns};
                end
                if (wb_req_i.adr == ch_addr(OFF_RLD_BASE, ch, 1'b0)) begin
                    next_rdata = rld_stage[ch].sec;
                end
                if (wb_req_i.adr == ch_addr(OFF_RLD_BASE, ch, 1'b1)) begin
                    next_rdata = {2'h0, rld_stage[ch].ns};
                end
            end
        end

        if (wr) begin
            unique case (wb_req_i.adr)
                OFF_CMD:       next_cmd = CMD_W'(merge(32'h0, wb_req_i.dat, wb_req_i.sel));
                OFF_CLK_SEC:   next_val_sec = merge(val_sec, wb_req_i.dat, wb_req_i.sel);
                OFF_CLK_NS:    next_val_ns = 30'(merge({2'h0, val_ns}, wb_req_i.dat,
                                                       wb_req_i.sel));
                OFF_CLK_SUB:   next_val_sub = merge(val_sub, wb_req_i.dat, wb_req_i.sel);
                OFF_TRIM:      next_trim = merge(trim, wb_req_i.dat, wb_req_i.sel);
                OFF_STEP:      next_step = merge(step, wb_req_i.dat, wb_req_i.sel);
                OFF_TEMP_RATE: next_temp_rate = merge(temp_rate, wb_req_i.dat, wb_req_i.sel);
                OFF_TEMP_LEN:  next_temp_len = merge(temp_len, wb_req_i.dat, wb_req_i.sel);
                OFF_CONFIG:    next_reload_sel = NCH'(merge({30'h0, reload_sel},
                                                             wb_req_i.dat, wb_req_i.sel));
                // write one to clear
                OFF_STATUS:    next_status = status & ~NCH'(merge(32'h0, wb_req_i.dat,
                                                                  wb_req_i.sel));
                default:       next_rdata = rdata;
            endcase
            for (int ch = 0; ch < NCH; ch++) begin
                if (wb_req_i.adr == ch_addr(OFF_TGT_BASE, ch, 1'b0)) begin
                    next_tgt_stage[ch].sec = merge(tgt_stage[ch].sec, wb_req_i.dat,
                                                   wb_req_i.sel);
                    next_tgt_half[ch][0] = 1'b1;
                end
                if (wb_req_i.adr == ch_addr(OFF_TGT_BASE, ch, 1'b1)) begin
                    next_tgt_stage[ch].ns = 30'(merge({2'h0, tgt_stage[ch].ns},
                                                      wb_req_i.dat, wb_req_i.sel));
                    next_tgt_half[ch][1] = 1'b1;
                end
                if (wb_req_i.adr == ch_addr(OFF_RLD_BASE, ch, 1'b0)) begin
                    next_rld_stage[ch].sec = merge(rld_stage[ch].sec, wb_req_i.dat,
                                                   wb_req_i.sel);
                    next_rld_half[ch][0] = 1'b1;
                end
                if (wb_req_i.adr == ch_addr(OFF_RLD_BASE, ch, 1'b1)) begin
                    next_rld_stage[ch].ns = 30'(merge({2'h0, rld_stage[ch].ns},
                                                      wb_req_i.dat, wb_req_i.sel));
                    next_rld_half[ch][1] = 1'b1;
                end
            end
        end

        rate_amt = temp_on ? temp_rate[30:0] : trim[30:0];
        rate_dir = temp_on ? temp_rate[DIR_BIT] : trim[DIR_BIT];
        sub_sum  = {1'b0, sub} + {2'h0, rate_amt};
        sub_wrap = sub_sum[32];
        next_sub = sub_sum[31:0];
        addend = sub_wrap ? (rate_dir ? INC_FAST : INC_SLOW) : INC_NORM;
        // step replaces the normal increment for one cycle
        if (cmd[CMD_STEP_NS]) begin
            addend = step[29:0];
        end
        ns_sum   = {1'b0, ns} + {1'b0, addend};
        ns_carry = ns_sum >= NS_WRAP31;
        next_ns  = ns_carry ? 30'(ns_sum - NS_WRAP31) : ns_sum[29:0];
        next_sec = sec + {31'h0, ns_carry};
        // seconds step; wrap carry added as well
        if (cmd[CMD_STEP_SEC]) begin
            next_sec = step[DIR_BIT] ? next_sec - {2'h0, step[29:0]}
                                     : next_sec + {2'h0, step[29:0]};
        end
        // direct load wins over every other update
        if (cmd[CMD_LOAD]) begin
            next_sec = val_sec;
            next_ns  = val_ns;
            next_sub = val_sub;
        end
        if (cmd[CMD_SNAP]) begin
            next_val_sec = sec;
            next_val_ns  = ns;
            next_val_sub = sub;
        end
        // duration counter; a zero duration leaves the normal rate in charge
        if (cmd[CMD_TEMP]) begin
            next_temp_on   = temp_len != 32'h0;
            next_temp_left = temp_len;
        end else if (temp_on) begin
            next_temp_left = temp_left - 32'h0000_0001;
            next_temp_on   = temp_left != 32'h0000_0001;
        end

        for (int ch = 0; ch < NCH; ch++) begin
            // comparator; also fires after a load past target
            hit[ch] = {sec, ns} >= {tgt[ch].sec, tgt[ch].ns};
            if (hit[ch]) begin
                // flag set wins over a same cycle clear
                next_status[ch] = 1'b1;
                next_evt[ch]    = 1'b1;
                next_tgt[ch] = reload_sel[ch] ? rld[ch] : add_time(tgt[ch], rld[ch]);
            end
            // commit after both halves, a fresh target beats the auto update
            if (next_tgt_half[ch] == 2'b11) begin
                next_tgt[ch]      = next_tgt_stage[ch];
                next_tgt_half[ch] = 2'b00;
            end
            if (next_rld_half[ch] == 2'b11) begin
                next_rld[ch]      = next_rld_stage[ch];
                next_rld_half[ch] = 2'b00;
            end
            if (cmd[CMD_TGT_READ]) begin
                next_tgt_stage[ch] = tgt[ch];
            end
        end
    end

    // command bits are registered for one cycle only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sec        <= '0;
            ns         <= '0;
            sub        <= '0;
            cmd        <= '0;
            val_sec    <= '0;
            val_ns     <= '0;
            val_sub    <= '0;
            trim       <= '0;
            step       <= '0;
            temp_rate  <= '0;
            temp_len   <= '0;
            temp_left  <= '0;
            temp_on    <= 1'b0;
            reload_sel <= '0;
            status     <= '0;
            evt        <= '0;
            ack        <= 1'b0;
            rdata      <= '0;
            for (int ch = 0; ch < NCH; ch++) begin
                tgt_stage[ch] <= '0;
                rld_stage[ch] <= '0;
                rld[ch]       <= '0;
                tgt_half[ch]  <= '0;
                rld_half[ch]  <= '0;
                // parked at the top so a fresh device raises no event
                tgt[ch]       <= '1;
            end
        end else begin
            sec        <= next_sec;
            ns         <= next_ns;
            sub        <= next_sub;
            cmd        <= next_cmd;
            val_sec    <= next_val_sec;
            val_ns     <= next_val_ns;
            val_sub    <= next_val_sub;
            trim       <= next_trim;
            step       <= next_step;
            temp_rate  <= next_temp_rate;
            temp_len   <= next_temp_len;
            temp_left  <= next_temp_left;
            temp_on    <= next_temp_on;
            reload_sel <= next_reload_sel;
            status     <= next_status;
            evt        <= next_evt;
            ack        <= next_ack;
            rdata      <= next_rdata;
            tgt_stage  <= next_tgt_stage;
            tgt        <= next_tgt;
            rld_stage  <= next_rld_stage;
            rld        <= next_rld;
            tgt_half   <= next_tgt_half;
            rld_half   <= next_rld_half;
        end
    end

    assign wb_ack_o            = ack;
    assign wb_dat_o            = rdata;
    assign channel_event_o     = evt;
    assign time_event_status_o = status;

    ns_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ns < NS_WRAP) else $error("nanoseconds out of range");

    ns_normal_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (cmd == '0 && !sub_wrap && !ns_carry) |=> ns == $past(ns) + INC_NORM)
        else $error("normal increment wrong");

    trim_inc_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (cmd == '0 && sub_wrap && !ns_carry)
        |=> ns == $past(ns) + ($past(rate_dir) ? INC_FAST : INC_SLOW))
        else $error("trimmed increment wrong");

    sec_carry_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ns_carry && !cmd[CMD_LOAD])
        |=> sec == $past(sec) + 32'h1 + ($past(cmd[CMD_STEP_SEC])
            ? ($past(step[DIR_BIT]) ? -{2'h0, $past(step[29:0])} : {2'h0, $past(step[29:0])})
            : 32'h0))
        else $error("seconds carry wrong");

    load_now_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cmd[CMD_LOAD] |=> sec == $past(val_sec) && ns == $past(val_ns) && sub == $past(val_sub))
        else $error("load not applied");

    snap_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cmd[CMD_SNAP] |=> val_sec == $past(sec) && val_ns == $past(ns))
        else $error("snapshot not taken");

    ns_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (cmd == 6'h08 && !ns_carry) |=> ns == $past(ns) + $past(step[29:0]))
        else $error("nanosecond step wrong");

    cmd_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cmd != '0 |=> cmd == '0) else $error("command bit stuck");

    flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        hit[0] |=> status[0] && channel_event_o[0]) else $error("channel flag not set");

    reload_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (hit[1] && reload_sel[1] && tgt_half[1] == 2'b00 && !wr) |=> tgt[1] == $past(rld[1]))
        else $error("reload target wrong");

    temp_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (temp_on && temp_left == 32'h1 && !cmd[CMD_TEMP]) |=> !temp_on)
        else $error("temporary rate overran");

endmodule

`default_nettype wire

// >>> dv/ptp_clock_event_timer_bench.sv
// bench for the precision clock and event timer, driven over classic wishbone
// assumes one 40 MHz clock that stands for the reference clock and an ack for every cycle
`timescale 1ns/1ps
`default_nettype none
module ptp_clock_event_timer_bench;
    import ptp_timer_pkg::*;
    logic           clk_i;
    logic           rst_i;
    wb_req_t        wb_req_i;
    logic [31:0]    wb_dat_o;
    logic           wb_ack_o;
    logic [NCH-1:0] channel_event_o;
    logic [NCH-1:0] time_event_status_o;
    int             bad_count;
    int             comparisons;
    logic [31:0]    d0;
    logic [31:0]    rd_val;

    ptp_clock_event_timer uut (
        .clk_i               (clk_i),
        .rst_i               (rst_i),
        .wb_req_i            (wb_req_i),
        .wb_dat_o            (wb_dat_o),
        .wb_ack_o            (wb_ack_o),
        .channel_event_o     (channel_event_o),
        .time_event_status_o (time_event_status_o)
    );

    initial clk_i = 1'b0;
    always #12.5 clk_i = ~clk_i;

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask

    // one classic cycle; request held until ack is sampled, then a cycle with cyc low
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_req_i <= '{1'b1, 1'b1, we, adr, 4'hf, dat};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd_val = wb_dat_o;
        wb_req_i <= '0;
        if (n >= 50) check("ack", 1, 0);
    endtask

    task automatic wait_ev(input int ch, output int n);
        n = 0;
        while (channel_event_o[ch] !== 1'b1 && n < 300) begin
            @(posedge clk_i);
            n++;
        end
    endtask

    // same bus sequence each time, so the cycle count from load to snapshot never changes
    task automatic measure(input logic [31:0] trim, input logic [31:0] mid,
                           output logic [31:0] sec, output logic [31:0] ns);
        bus(1, OFF_TRIM, trim);
        bus(1, OFF_CLK_SEC, 32'h0000_0064);
        bus(1, OFF_CLK_NS, 32'h0000_0000);
        // sub-ns parked mid-range so a short temporary rate still wraps before the snapshot
        bus(1, OFF_CLK_SUB, 32'h8000_0000);
        bus(1, OFF_CMD, 32'h0000_0002);
        bus(1, OFF_CMD, mid);
        bus(1, OFF_CMD, 32'h0000_0001);
        bus(0, OFF_CLK_SEC, '0);
        sec = rd_val;
        bus(0, OFF_CLK_NS, '0);
        ns = rd_val;
        bus(0, OFF_CMD, '0);
        check("cmd clear", 0, rd_val);
    endtask

    task automatic rate_tests();
        logic [31:0] s;
        logic [31:0] d1;
        logic [31:0] d2;
        logic [31:0] dt;
        bus(1, OFF_STEP, 32'h8000_0003);
        bus(1, OFF_TEMP_RATE, 32'hffff_ffff);
        bus(1, OFF_TEMP_LEN, 32'h0000_0004);
        measure(32'h0, 32'h0, s, d0);
        check("sec after load", 32'h64, s);
        check("ns in tens", 0, d0 % 10);
        measure(32'hffff_ffff, 32'h0, s, d1);
        check("fast trim", 1, d1 > d0);
        measure(32'h7fff_ffff, 32'h0, s, d2);
        check("slow trim", 1, d2 < d0);
        measure(32'h0, 32'h10, s, dt);
        check("temporary rate", 1, dt > d0 && dt < d1);
        measure(32'h0, 32'h4, s, dt);
        check("sec step", 32'h61, s);
        check("ns kept", d0, dt);
        measure(32'h0, 32'h8, s, dt);
        check("ns step", d0 - 7, dt);
    endtask

    task automatic wrap_test();
        bus(1, OFF_CLK_SEC, 32'h0000_0064);
        bus(1, OFF_CLK_NS, 32'h3b9a_c9f6);
        bus(1, OFF_CMD, 32'h0000_0002);
        bus(1, OFF_CMD, 32'h0000_0001);
        bus(0, OFF_CLK_SEC, '0);
        check("sec carry", 32'h65, rd_val);
        bus(0, OFF_CLK_NS, '0);
        check("ns wrapped", 1, rd_val < 32'h100 && rd_val % 10 == 0);
    endtask

    task automatic event_test();
        int n;
        bus(1, OFF_CONFIG, 32'h0);
        bus(1, OFF_CLK_SEC, 32'h0000_0064);
        bus(1, OFF_CLK_NS, 32'h0000_0000);
        bus(1, OFF_CMD, 32'h0000_0002);
        bus(1, OFF_TGT_BASE, 32'h0000_0064);
        bus(1, OFF_TGT_BASE + OFF_NS_HALF, 32'h0000_0400);
        bus(1, OFF_RLD_BASE, 32'h0);
        bus(1, OFF_RLD_BASE + OFF_NS_HALF, 32'h0000_0100);
        check("no early flag", 0, time_event_status_o);
        wait_ev(0, n);
        check("event a", 1, n < 300);
        bus(0, OFF_STATUS, '0);
        check("status a", 1, rd_val[0]);
        wait_ev(0, n);
        check("added target", 1, n < 40);
        bus(1, OFF_CMD, 32'h0000_0020);
        bus(0, OFF_TGT_BASE + OFF_NS_HALF, '0);
        check("target read", 1, rd_val[7:0] == 8'h00 && rd_val >= 32'h500);
        // a lone half must leave channel b at its never-reached reset target
        bus(1, OFF_TGT_BASE + OFF_CH_STRIDE, 32'h0);
        repeat (5) @(posedge clk_i);
        check("half pair", 0, time_event_status_o[1]);
        bus(1, OFF_TGT_BASE + OFF_CH_STRIDE + OFF_NS_HALF, 32'h0000_0010);
        wait_ev(1, n);
        check("past target", 1, n < 5);
        // channel b keeps firing; in reload mode its target becomes the zero reload pair
        bus(1, OFF_CONFIG, 32'h0000_0002);
        bus(1, OFF_CMD, 32'h0000_0020);
        bus(0, OFF_TGT_BASE + OFF_CH_STRIDE + OFF_NS_HALF, '0);
        check("reload target", 0, rd_val);
    endtask

    task automatic print_verdict();
        if (bad_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        bad_count = 0;
        comparisons = 0;
        rst_i = 1'b1;
        wb_req_i = '0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        check("status reset", 0, time_event_status_o);
        rate_tests();
        wrap_test();
        event_test();
        print_verdict();
    end

    initial begin
        #(25 * 20000);
        bad_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
